// file: logic/rbc_cfg.svh
// Purpose: constants for the receive bit framing and collision status block
// Assumes: 8-bit registers on a plain strobe port
// Notes:   offsets are register addresses on the port
`ifndef RBC_CFG_SVH
`define RBC_CFG_SVH
`define RBC_ADDR_W        8
`define RBC_OFS_STATUS    8'h0b
`define RBC_OFS_BITCTRL   8'h0c
`define RBC_OFS_COLL      8'h0d
`define RBC_OFS_IRQ_STAT  8'h20
`define RBC_OFS_IRQ_MASK  8'h21
`define RBC_OFS_FAULTS    8'h22
`define RBC_BIT_KEEP      7
`define RBC_BIT_CLASH_INT 3
`define RBC_BIT_CLASH_DET 2
`define RBC_BIT_INTEG     0
`define RBC_COLL_MAX      7'h3f
`define RBC_BITCTRL_RST   8'h00
`define RBC_CODE_IDLE     3'h0
`define RBC_CODE_TXWAIT   3'h1
`define RBC_CODE_TX       3'h3
`define RBC_CODE_RXWAIT   3'h5
`define RBC_CODE_WAITDATA 3'h6
`define RBC_CODE_RX       3'h7
`define RBC_IRQ_W         3
`define RBC_IRQ_COLL      0
`define RBC_IRQ_INTEG     1
`define RBC_IRQ_RXDONE    2
`endif

// file: logic/rbc_pkg.sv
// Purpose: types for the receive bit framing and collision status block
// Assumes: constants live in rbc_cfg.svh
// Notes:   phase enum mirrors the transmit/receive sequencer
package rbc_pkg;
	typedef enum logic [2:0] {
		PH_IDLE, PH_TXWAIT, PH_TX, PH_RXWAIT, PH_WAITDATA, PH_RX
	} rbc_phase_t;
endpackage

// file: logic/rbc_phase.sv
// Purpose: transmit/receive phase tracker with coded output
// Assumes: sequencer events are one-cycle pulses on clk
// Notes:   code comes from a register
`timescale 1ns/1ps
`include "rbc_cfg.svh"
module rbc_phase (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Sequencer events
	input  wire logic       tx_start,
	input  wire logic       tx_go,
	input  wire logic       tx_end,
	input  wire logic       rx_arm,
	input  wire logic       rx_sof,
	input  wire logic       rx_end,
	input  wire logic       abort,
	// Phase
	output rbc_pkg::rbc_phase_t phase,
	output logic [2:0]      txrx_phase_code
);
	typedef struct packed {
		rbc_pkg::rbc_phase_t ph;
		logic [2:0]          code;
	} rbc_ph_st_t;
	rbc_ph_st_t s_r, s_nxt;

	function automatic logic [2:0] code_of(rbc_pkg::rbc_phase_t p);
		case (p)
			rbc_pkg::PH_TXWAIT:   code_of = `RBC_CODE_TXWAIT;
			rbc_pkg::PH_TX:       code_of = `RBC_CODE_TX;
			rbc_pkg::PH_RXWAIT:   code_of = `RBC_CODE_RXWAIT;
			rbc_pkg::PH_WAITDATA: code_of = `RBC_CODE_WAITDATA;
			rbc_pkg::PH_RX:       code_of = `RBC_CODE_RX;
			default:              code_of = `RBC_CODE_IDLE;
		endcase
	endfunction

	always_comb begin
		s_nxt = s_r;
		case (s_r.ph)
			rbc_pkg::PH_IDLE: begin
				if (tx_start)
					s_nxt.ph = rbc_pkg::PH_TXWAIT;
				else if (rx_arm)
					s_nxt.ph = rbc_pkg::PH_WAITDATA;
			end
			rbc_pkg::PH_TXWAIT: begin
				if (tx_go)
					s_nxt.ph = rbc_pkg::PH_TX;
			end
			rbc_pkg::PH_TX: begin
				if (tx_end)
					s_nxt.ph = rbc_pkg::PH_RXWAIT;
			end
			rbc_pkg::PH_RXWAIT: begin
				if (rx_arm)
					s_nxt.ph = rbc_pkg::PH_WAITDATA;
			end
			rbc_pkg::PH_WAITDATA: begin
				if (rx_sof)
					s_nxt.ph = rbc_pkg::PH_RX;
			end
			rbc_pkg::PH_RX: begin
				if (rx_end)
					s_nxt.ph = rbc_pkg::PH_IDLE;
			end
			default: s_nxt.ph = rbc_pkg::PH_IDLE;
		endcase
		if (abort)
			s_nxt.ph = rbc_pkg::PH_IDLE;
		s_nxt.code = code_of(s_nxt.ph);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= '{rbc_pkg::PH_IDLE, 3'h0};
		else
			s_r <= s_nxt;
	end

	assign phase           = s_r.ph;
	assign txrx_phase_code = s_r.code;

	code_unused_a: assert property (
		@(posedge clk) disable iff (rst)
		s_r.code != 3'h4 && s_r.code != 3'h2)
		else $error("phase code out of set");
endmodule

// file: logic/rbc_assembler.sv
// Purpose: places received bits into bytes at the aligned position
// Assumes: bit_valid pulses once per data bit during a frame
// Notes:   byte output registered; zero fill after a clash is upstream
`timescale 1ns/1ps
module rbc_assembler (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Frame control
	input  wire logic       frame_start,
	input  wire logic [2:0] first_bit_position,
	// Bit stream
	input  wire logic       bit_valid,
	input  wire logic       bit_value,
	input  wire logic       frame_end,
	// Byte out
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic [2:0]      bit_ptr
);
	typedef struct packed {
		logic [7:0] acc;
		logic [2:0] ptr;
		logic       has;
		logic       bv;
		logic [7:0] bd;
	} rbc_asm_st_t;
	rbc_asm_st_t s_r, s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.bv = 1'b0;
		if (frame_start) begin
			s_nxt.ptr = first_bit_position;
			s_nxt.acc = 8'h00;
			s_nxt.has = 1'b0;
		end else if (bit_valid) begin
			s_nxt.acc[s_r.ptr] = bit_value;
			s_nxt.has = 1'b1;
			s_nxt.ptr = s_r.ptr + 3'h1;
			if (s_r.ptr == 3'h7) begin
				s_nxt.bv  = 1'b1;
				s_nxt.bd  = s_nxt.acc;
				s_nxt.acc = 8'h00;
				s_nxt.has = 1'b0;
			end
		end else if (frame_end && s_r.has) begin
			s_nxt.bv  = 1'b1;
			s_nxt.bd  = s_r.acc;
			s_nxt.acc = 8'h00;
			s_nxt.has = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign byte_valid = s_r.bv;
	assign byte_data  = s_r.bd;
	assign bit_ptr    = s_r.ptr;

	align_load_a: assert property (
		@(posedge clk) disable iff (rst)
		frame_start |=> s_r.ptr == $past(first_bit_position))
		else $error("first bit position not loaded");
endmodule

// file: logic/rbc_top.sv
// Purpose: receive bit framing, collision position and phase status
// Assumes: all inputs are synchronous to clk except the raw rf bit pins
// Notes:   one level interrupt from sticky, mask-gated event bits
// Behaviour
// - Phase code reads idle 0, txwait 1, tx 3, rxwait 5, wait 6, rx 7.
// - With keep bit clear, bits after a clash are stored as zero.
// - First bit lands at the alignment position; later bits follow on.
// - Alignment zero means byte-oriented, nonzero means bit-oriented.
// - With clash-as-integrity set, a clash also raises the integrity fault.
// - Final-byte valid bits field counts valid bits; zero means eight.
// - Decoder writes that field at bit-oriented end, clears it at start.
// - Position valid flag set only when the stored position is valid.
// - Seven-bit zero-based position of the first clash among data bits.
// - Positions only within the first eight bytes, 3Fh highest.
// - Nonzero alignment is added into the reported position.
// - A clash sets the clash detected flag and records its position.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "rbc_cfg.svh"
module rbc_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	// Sequencer events
	input  wire logic       tx_start,
	input  wire logic       tx_go,
	input  wire logic       tx_end,
	input  wire logic       rx_arm,
	input  wire logic       abort,
	// Receive decoder pins
	input  wire logic       rf_sof,
	input  wire logic       rf_bit_valid,
	input  wire logic       rf_bit_value,
	input  wire logic       rf_bit_clash,
	input  wire logic       rf_eof,
	// Outputs
	output logic            rx_byte_valid,
	output logic [7:0]      rx_byte_data,
	output logic            clash_detected_flag,
	output logic            integrity_fault_flag,
	output logic            irq
);
	typedef struct packed {
		logic [2:0]  sof_s;
		logic [2:0]  bv_s;
		logic [2:0]  val_s;
		logic [2:0]  cl_s;
		logic [2:0]  eof_s;
		logic        keep_bits_after_clash;
		logic [2:0]  first_bit_position;
		logic        clash_as_integrity_fault;
		logic [2:0]  final_byte_valid_bits;
		logic        clash_position_valid;
		logic [6:0]  clash_position;
		logic        clash_seen;
		logic [9:0]  bit_cnt;
		logic        clash_det;
		logic        integ;
		logic [`RBC_IRQ_W-1:0] ist;
		logic [`RBC_IRQ_W-1:0] imask;
		logic [7:0]  rdata;
		logic        irq;
	} rbc_st_t;
	rbc_st_t s_r, s_nxt;

	rbc_pkg::rbc_phase_t phase;
	logic [2:0]          txrx_phase_code;
	logic                asm_bv;
	logic [7:0]          asm_bd;
	logic [2:0]          asm_ptr;

	// Synchronised decoder strobes, bit [1] is the second stage
	logic sof_e;
	logic bit_e;
	logic eof_e;
	logic clash_e;
	logic stored_bit;
	logic bit_oriented;
	logic [9:0] pos_full;

	function automatic logic [9:0] clash_pos(logic [9:0] cnt,
		logic [2:0] align);
		clash_pos = cnt + {7'h00, align};
	endfunction

	assign sof_e   = s_r.sof_s[1] & ~s_r.sof_s[2];
	assign bit_e   = s_r.bv_s[1] & ~s_r.bv_s[2];
	assign eof_e   = s_r.eof_s[1] & ~s_r.eof_s[2];
	assign clash_e = bit_e & s_r.cl_s[1];
	assign bit_oriented = s_r.first_bit_position != 3'h0;
	assign stored_bit = (s_r.clash_seen | clash_e)
		& ~s_r.keep_bits_after_clash ? 1'b0 : s_r.val_s[1];
	assign pos_full = clash_pos(s_r.bit_cnt, s_r.first_bit_position);

	rbc_phase u_phase (
		.clk             (clk),
		.rst             (rst),
		.tx_start        (tx_start),
		.tx_go           (tx_go),
		.tx_end          (tx_end),
		.rx_arm          (rx_arm),
		.rx_sof          (sof_e),
		.rx_end          (eof_e),
		.abort           (abort),
		.phase           (phase),
		.txrx_phase_code (txrx_phase_code)
	);

	rbc_assembler u_asm (
		.clk                (clk),
		.rst                (rst),
		.frame_start        (sof_e),
		.first_bit_position (s_r.first_bit_position),
		.bit_valid          (bit_e),
		.bit_value          (stored_bit),
		.frame_end          (eof_e),
		.byte_valid         (asm_bv),
		.byte_data          (asm_bd),
		.bit_ptr            (asm_ptr)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.sof_s = {s_r.sof_s[1:0], rf_sof};
		s_nxt.bv_s  = {s_r.bv_s[1:0], rf_bit_valid};
		s_nxt.val_s = {s_r.val_s[1:0], rf_bit_value};
		s_nxt.cl_s  = {s_r.cl_s[1:0], rf_bit_clash};
		s_nxt.eof_s = {s_r.eof_s[1:0], rf_eof};
		s_nxt.rdata = 8'h00;

		if (rx_arm) begin
			s_nxt.clash_det = 1'b0;
			s_nxt.integ     = 1'b0;
		end
		if (sof_e) begin
			s_nxt.final_byte_valid_bits = 3'h0;
			s_nxt.clash_seen           = 1'b0;
			s_nxt.clash_position_valid = 1'b0;
			s_nxt.clash_position       = 7'h00;
			s_nxt.bit_cnt              = 10'h000;
		end
		if (bit_e && phase == rbc_pkg::PH_RX) begin
			if (s_r.bit_cnt != 10'h3ff)
				s_nxt.bit_cnt = s_r.bit_cnt + 10'h001;
			if (clash_e && !s_r.clash_seen) begin
				s_nxt.clash_seen = 1'b1;
				s_nxt.clash_det  = 1'b1;
				if (s_r.clash_as_integrity_fault)
					s_nxt.integ = 1'b1;
				if (pos_full <= {3'h0, `RBC_COLL_MAX}) begin
					s_nxt.clash_position = pos_full[6:0];
					s_nxt.clash_position_valid = 1'b1;
				end
			end
		end
		if (eof_e && bit_oriented)
			s_nxt.final_byte_valid_bits = asm_ptr;

		// Register writes
		if (wr && addr == `RBC_OFS_BITCTRL) begin
			s_nxt.keep_bits_after_clash    = wdata[`RBC_BIT_KEEP];
			s_nxt.first_bit_position       = wdata[6:4];
			s_nxt.clash_as_integrity_fault = wdata[`RBC_BIT_CLASH_INT];
		end
		if (wr && addr == `RBC_OFS_IRQ_MASK)
			s_nxt.imask = wdata[`RBC_IRQ_W-1:0];

		// Sticky events: set wins over write-one-to-clear
		if (wr && addr == `RBC_OFS_IRQ_STAT)
			s_nxt.ist = s_r.ist & ~wdata[`RBC_IRQ_W-1:0];
		if (s_nxt.clash_det & ~s_r.clash_det)
			s_nxt.ist[`RBC_IRQ_COLL] = 1'b1;
		if (s_nxt.integ & ~s_r.integ)
			s_nxt.ist[`RBC_IRQ_INTEG] = 1'b1;
		if (eof_e)
			s_nxt.ist[`RBC_IRQ_RXDONE] = 1'b1;
		s_nxt.irq = |(s_nxt.ist & s_nxt.imask);

		if (rd) begin
			case (addr)
				`RBC_OFS_STATUS:
					s_nxt.rdata = {5'h00, txrx_phase_code};
				`RBC_OFS_BITCTRL:
					s_nxt.rdata = {s_r.keep_bits_after_clash,
						s_r.first_bit_position,
						s_r.clash_as_integrity_fault,
						s_r.final_byte_valid_bits};
				`RBC_OFS_COLL:
					s_nxt.rdata = {s_r.clash_position_valid,
						s_r.clash_position};
				`RBC_OFS_IRQ_STAT:
					s_nxt.rdata = {5'h00, s_r.ist};
				`RBC_OFS_IRQ_MASK:
					s_nxt.rdata = {5'h00, s_r.imask};
				`RBC_OFS_FAULTS:
					s_nxt.rdata = {5'h00, s_r.clash_det, 1'b0, s_r.integ};
				default:
					s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign rdata                = s_r.rdata;
	assign rx_byte_valid        = asm_bv;
	assign rx_byte_data         = asm_bd;
	assign clash_detected_flag  = s_r.clash_det;
	assign integrity_fault_flag = s_r.integ;
	assign irq                  = s_r.irq;

	// Register read path
	status_reserved_a: assert property (
		@(posedge clk) disable iff (rst)
		rd && addr == `RBC_OFS_STATUS |=> rdata[7:3] == 5'h00)
		else $error("reserved status bits not zero");
	phase_read_a: assert property (
		@(posedge clk) disable iff (rst)
		rd && addr == `RBC_OFS_STATUS
		|=> rdata[2:0] == $past(txrx_phase_code))
		else $error("phase code read wrong");
	coll_read_a: assert property (
		@(posedge clk) disable iff (rst)
		rd && addr == `RBC_OFS_COLL
		|=> rdata[7] == $past(s_r.clash_position_valid)
		&& rdata[6:0] == $past(s_r.clash_position))
		else $error("collision register read wrong");
	read_idle_a: assert property (
		@(posedge clk) disable iff (rst)
		!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");

	// Collision capture and bit handling
	zero_fill_a: assert property (
		@(posedge clk) disable iff (rst)
		bit_e && s_r.clash_seen && !s_r.keep_bits_after_clash
		|-> !stored_bit)
		else $error("bit after clash not zeroed");
	clash_integ_a: assert property (
		@(posedge clk) disable iff (rst)
		bit_e && clash_e && !s_r.clash_seen && phase == rbc_pkg::PH_RX
		&& s_r.clash_as_integrity_fault |=> integrity_fault_flag)
		else $error("clash did not raise integrity fault");
	integ_quiet_a: assert property (
		@(posedge clk) disable iff (rst)
		!s_r.integ && !(clash_e && s_r.clash_as_integrity_fault)
		|=> !integrity_fault_flag)
		else $error("integrity fault without a clash");
	clash_flag_a: assert property (
		@(posedge clk) disable iff (rst)
		bit_e && clash_e && phase == rbc_pkg::PH_RX
		|=> clash_detected_flag)
		else $error("clash flag not set");
	pos_range_a: assert property (
		@(posedge clk) disable iff (rst)
		s_r.clash_position_valid |-> s_r.clash_position <= 7'h3f)
		else $error("clash position out of range");
	pos_value_a: assert property (
		@(posedge clk) disable iff (rst)
		bit_e && clash_e && !s_r.clash_seen && phase == rbc_pkg::PH_RX
		&& pos_full <= 10'h03f |=> s_r.clash_position_valid
		&& s_r.clash_position == $past(pos_full[6:0]))
		else $error("clash position wrong");
	pos_invalid_a: assert property (
		@(posedge clk) disable iff (rst)
		bit_e && clash_e && !s_r.clash_seen && phase == rbc_pkg::PH_RX
		&& pos_full > 10'h03f |=> !s_r.clash_position_valid)
		else $error("out of range position flagged valid");
	pos_first_a: assert property (
		@(posedge clk) disable iff (rst)
		s_r.clash_seen && !sof_e
		|=> $stable(s_r.clash_position)
		&& $stable(s_r.clash_position_valid))
		else $error("later clash overwrote the position");
	pos_clear_a: assert property (
		@(posedge clk) disable iff (rst)
		sof_e && !bit_e |=> !s_r.clash_position_valid)
		else $error("position valid not cleared at frame start");

	// Control and final bits
	lastbits_clr_a: assert property (
		@(posedge clk) disable iff (rst)
		sof_e |=> s_r.final_byte_valid_bits == 3'h0)
		else $error("final bits not cleared");
	lastbits_set_a: assert property (
		@(posedge clk) disable iff (rst)
		eof_e && bit_oriented && !sof_e
		|=> s_r.final_byte_valid_bits == $past(asm_ptr))
		else $error("final bits not written");
	lastbits_ro_a: assert property (
		@(posedge clk) disable iff (rst)
		!sof_e && !eof_e |=> $stable(s_r.final_byte_valid_bits))
		else $error("final bits changed outside frame edges");
	lastbits_byte_a: assert property (
		@(posedge clk) disable iff (rst)
		eof_e && !bit_oriented && !sof_e
		|=> $stable(s_r.final_byte_valid_bits))
		else $error("final bits written in byte mode");
	bitctrl_write_a: assert property (
		@(posedge clk) disable iff (rst)
		wr && addr == `RBC_OFS_BITCTRL
		|=> s_r.first_bit_position == $past(wdata[6:4])
		&& s_r.keep_bits_after_clash == $past(wdata[`RBC_BIT_KEEP])
		&& s_r.clash_as_integrity_fault == $past(wdata[`RBC_BIT_CLASH_INT]))
		else $error("control fields not written");

	// Interrupt status
	irq_level_a: assert property (
		@(posedge clk) disable iff (rst)
		irq == |(s_r.ist & s_r.imask))
		else $error("irq does not follow status and mask");
	irq_clash_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(clash_detected_flag) |-> s_r.ist[`RBC_IRQ_COLL])
		else $error("clash event not held in status");
	irq_done_a: assert property (
		@(posedge clk) disable iff (rst)
		eof_e |=> s_r.ist[`RBC_IRQ_RXDONE])
		else $error("receive done not held in status");
endmodule

// file: verification/rbc_card_model.sv
// Purpose: transponder seen through the receive decoder pins
// Assumes: the block resynchronises every pin and acts on rising edges
// Notes:   the data line shows the inverted bit between strobes
`timescale 1ns/1ps
module rbc_card_model (
	// Clock
	input  wire logic clk,
	// Decoder pins
	output logic      rf_sof,
	output logic      rf_bit_valid,
	output logic      rf_bit_value,
	output logic      rf_bit_clash,
	output logic      rf_eof
);
	initial begin
		rf_sof = 1'b0;
		rf_bit_valid = 1'b0;
		rf_bit_value = 1'b0;
		rf_bit_clash = 1'b0;
		rf_eof = 1'b0;
	end

	task automatic wait_n(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic frame_start();
		@(posedge clk);
		rf_sof <= 1'b1;
		wait_n(3);
		rf_sof <= 1'b0;
		wait_n(3);
	endtask

	// Value and clash stay put well across the synchronised strobe edge
	task automatic send_bit(logic v, logic c);
		@(posedge clk);
		rf_bit_value <= v;
		rf_bit_clash <= c;
		@(posedge clk);
		rf_bit_valid <= 1'b1;
		wait_n(4);
		rf_bit_valid <= 1'b0;
		wait_n(2);
		rf_bit_value <= ~v;
		rf_bit_clash <= 1'b0;
	endtask

	task automatic frame_end();
		@(posedge clk);
		rf_eof <= 1'b1;
		wait_n(3);
		rf_eof <= 1'b0;
		wait_n(3);
	endtask
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench for the receive framing status block
// Assumes: partner model drives the decoder pins
// Notes:   received bytes are collected in a queue as they appear
`timescale 1ns/1ps
`include "rbc_cfg.svh"
module testbench;
	logic       clk;
	logic       rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [4:0] ev;
	logic       sof, bv, bval, bcl, eof;
	logic       byte_v;
	logic [7:0] byte_d;
	logic       clash_f;
	logic       integ_f;
	logic       irq;
	int         miscompares;
	int         checked;
	logic [7:0] bq[$];

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	rbc_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .tx_start(ev[0]),
		.tx_go(ev[1]), .tx_end(ev[2]), .rx_arm(ev[3]), .abort(ev[4]),
		.rf_sof(sof), .rf_bit_valid(bv), .rf_bit_value(bval),
		.rf_bit_clash(bcl), .rf_eof(eof), .rx_byte_valid(byte_v),
		.rx_byte_data(byte_d), .clash_detected_flag(clash_f),
		.integrity_fault_flag(integ_f), .irq(irq));

	rbc_card_model card (.clk(clk), .rf_sof(sof), .rf_bit_valid(bv),
		.rf_bit_value(bval), .rf_bit_clash(bcl), .rf_eof(eof));

	always @(posedge clk) begin
		if (byte_v === 1'b1) begin
			bq.push_back(byte_d);
		end
	end

	task automatic print_verdict();
		$display("Counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		// Step past the edge so registered outputs have settled
		#1;
	endtask

	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	task automatic pulse(int i);
		@(posedge clk);
		ev <= 5'h01 << i;
		@(posedge clk);
		ev <= 5'h00;
	endtask

	task automatic wait_bytes(int n);
		int k;
		for (k = 0; k < 60 && bq.size() < n; k++) @(posedge clk);
		if (bq.size() < n) begin
			$display("Error at %0t: byte wait timed out", $time);
			miscompares++;
			print_verdict();
		end
	endtask

	task automatic run_frame(logic [7:0] ctl, int n, int ci);
		int i;
		bq.delete();
		wr_reg(`RBC_OFS_BITCTRL, ctl);
		pulse(3);
		card.frame_start();
		for (i = 0; i < n; i++) card.send_bit(1'b1, i == ci);
		card.frame_end();
	endtask

	task automatic test_reset();
		rd_chk(`RBC_OFS_STATUS, 8'h00);
		wr_reg(`RBC_OFS_STATUS, 8'hff);
		rd_chk(`RBC_OFS_STATUS, 8'h00);
		rd_chk(`RBC_OFS_BITCTRL, `RBC_BITCTRL_RST);
		rd_chk(`RBC_OFS_COLL, 8'h00);
		rd_chk(8'h40, 8'h00);
		$display("test_reset done");
	endtask

	task automatic test_phase();
		int evs[8] = '{0, 1, 2, 3, 5, 6, 0, 4};
		logic [2:0] exp[8] = '{`RBC_CODE_TXWAIT, `RBC_CODE_TX,
			`RBC_CODE_RXWAIT, `RBC_CODE_WAITDATA, `RBC_CODE_RX,
			`RBC_CODE_IDLE, `RBC_CODE_TXWAIT, `RBC_CODE_IDLE};
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			if (evs[i] < 5) pulse(evs[i]);
			else if (evs[i] == 5) card.frame_start();
			else card.frame_end();
			rd_reg(`RBC_OFS_STATUS, d);
			chk(d, {5'h00, exp[i]});
		end
		$display("test_phase done");
	endtask

	// Align 4, clash on the fourth bit, six bits in all
	task automatic test_align_clash();
		run_frame(8'h4f, 6, 3);
		wait_bytes(2);
		chk({bq[0][7:4], 4'h0}, 8'h70);
		chk({6'h00, bq[1][1:0]}, 8'h00);
		rd_chk(`RBC_OFS_BITCTRL, 8'h4a);
		rd_chk(`RBC_OFS_COLL, 8'h87);
		chk({6'h00, clash_f, integ_f}, 8'h03);
		rd_chk(`RBC_OFS_FAULTS, 8'h05);
		wr_reg(`RBC_OFS_IRQ_MASK, 8'h01);
		rd_chk(`RBC_OFS_IRQ_MASK, 8'h01);
		cyc(2);
		chk({7'h00, irq}, 8'h01);
		rd_chk(`RBC_OFS_IRQ_STAT, 8'h07);
		wr_reg(`RBC_OFS_IRQ_STAT, 8'h01);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		rd_chk(`RBC_OFS_IRQ_STAT, 8'h06);
		$display("test_align_clash done");
	endtask

	task automatic test_keep_byte();
		run_frame(8'h80, 8, 2);
		wait_bytes(1);
		chk(bq[0], 8'hff);
		rd_chk(`RBC_OFS_COLL, 8'h82);
		rd_chk(`RBC_OFS_BITCTRL, 8'h80);
		chk({6'h00, clash_f, integ_f}, 8'h02);
		$display("test_keep_byte done");
	endtask

	task automatic test_range();
		int cis[3] = '{63, 64, 99};
		logic [7:0] d;
		foreach (cis[j]) begin
			run_frame(8'h00, 65, cis[j]);
			wait_bytes(8);
			rd_reg(`RBC_OFS_COLL, d);
			if (cis[j] == 63) begin
				chk(d, 8'hbf);
				chk(bq[7], 8'h7f);
			end else begin
				chk(d & 8'h80, 8'h00);
			end
			chk({7'h00, clash_f}, {7'h00, cis[j] < 65});
		end
		$display("test_range done");
	endtask

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		ev = 5'h00;
		miscompares = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_phase();
		test_align_clash();
		test_keep_byte();
		test_range();
		print_verdict();
	end
endmodule
